// *** src/semc_defs.svh ***
`ifndef SEMC_DEFS_SVH
`define SEMC_DEFS_SVH

// register offsets (byte addresses)
`define SEMC_RAW_OFS      8'h38
`define SEMC_MASK_OFS     8'h3c
`define SEMC_CLEAR_OFS    8'h40
`define SEMC_SET_OFS      8'h44
`define SEMC_IRQ_STAT_OFS 8'h48
`define SEMC_IRQ_MASK_OFS 8'h4c

// reset values
`define SEMC_MASK_RST     32'h0000_0000
`define SEMC_CLEAR_RST    32'h0000_0000
`define SEMC_RAW_RST      32'h0000_0000

// implemented bit positions
`define SEMC_RAW_BITS     32'hff7f_008f
`define SEMC_MASK_BITS    32'hff6f_0089

// field positions
`define SEMC_BIT_WDT_PREWARN   0
`define SEMC_BIT_PERIODIC      1
`define SEMC_BIT_ALARM         2
`define SEMC_BIT_SUPPLY_PREW   3
`define SEMC_BIT_SUPPLY_DROP   7
`define SEMC_BIT_CLOCK_LOSS    16
`define SEMC_BIT_SRAM_PAR      17
`define SEMC_BIT_SERIAL_PAR    18
`define SEMC_BIT_FLASH_ECC2    19
`define SEMC_BIT_FLASH_DONE    20
`define SEMC_BIT_VCLIP         21
`define SEMC_BIT_SBY_CLK       22
`define SEMC_BIT_RTC_FIRST     24
`define SEMC_BIT_RTC_LAST      28
`define SEMC_BIT_TEMP_DONE     29
`define SEMC_BIT_TEMP_HIGH     30
`define SEMC_BIT_TEMP_LOW      31

// interrupt status bits of this block
`define SEMC_IRQ_REQ_RISE 0
`define SEMC_IRQ_SET_HIT  1

`endif

// *** src/semc_pkg.sv ***
package semc_pkg;

  typedef logic [31:0] semc_word_t;
  typedef logic [7:0]  semc_addr_t;

  // register port request
  typedef struct packed {
    semc_addr_t addr;
    semc_word_t wdata;
    logic       wr;
    logic       rd;
  } semc_req_s;

  // whole state of the block
  typedef struct packed {
    semc_word_t raw;
    semc_word_t mask;
    semc_word_t rdata;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic       req_q;
  } semc_state_s;

endpackage : semc_pkg

// *** src/semc_event_mask_clear.sv ***
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`include "semc_defs.svh"

module semc_event_mask_clear
  import semc_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            arst_n,
  input  wire semc_pkg::semc_req_s  bus_req,
  output semc_pkg::semc_word_t bus_rdata,
  input  wire semc_pkg::semc_word_t event_pulse,
  output semc_pkg::semc_word_t event_raw_status,
  output logic                 service_req,
  output logic                 irq
);

  import semc_pkg::*;

  semc_state_s st;
  semc_state_s next_st;

  logic wr_mask;
  logic wr_clear;
  logic wr_set;
  logic wr_istat;
  logic wr_imask;
  logic rd_istat;
  logic masked_any;
  logic set_hit;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  always_comb
  begin
    wr_mask  = 1'b0;
    wr_clear = 1'b0;
    wr_set   = 1'b0;
    wr_istat = 1'b0;
    wr_imask = 1'b0;
    if (bus_req.addr == `SEMC_MASK_OFS)
      wr_mask = bus_req.wr;
    else if (bus_req.addr == `SEMC_CLEAR_OFS)
      wr_clear = bus_req.wr;
    else if (bus_req.addr == `SEMC_SET_OFS)
      wr_set = bus_req.wr;
    else if (bus_req.addr == `SEMC_IRQ_STAT_OFS)
      wr_istat = bus_req.wr;
    else if (bus_req.addr == `SEMC_IRQ_MASK_OFS)
      wr_imask = bus_req.wr;
  end

  assign rd_istat = bus_req.rd && (bus_req.addr == `SEMC_IRQ_STAT_OFS);

  // masked request seen from the current raw status
  assign masked_any = |(st.raw & st.mask);
  assign set_hit    = wr_set && |(bus_req.wdata & `SEMC_RAW_BITS);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    next_st = st;
    // raw status: clear first, then events and set writes win
    if (wr_clear)
      next_st.raw = st.raw & ~bus_req.wdata;
    next_st.raw = next_st.raw | (event_pulse & `SEMC_RAW_BITS);
    if (wr_set)
      next_st.raw = next_st.raw | (bus_req.wdata & `SEMC_RAW_BITS);
    next_st.raw = next_st.raw & `SEMC_RAW_BITS;

    // mask: reserved positions stay zero
    if (wr_mask)
      next_st.mask = bus_req.wdata & `SEMC_MASK_BITS;

    if (wr_imask)
      next_st.irq_mask = bus_req.wdata[1:0];

    // sticky block events, read clears, new events win
    if (rd_istat)
      next_st.irq_stat = 2'h0;
    if (wr_istat)
      next_st.irq_stat = next_st.irq_stat;
    if (masked_any && !st.req_q)
      next_st.irq_stat[`SEMC_IRQ_REQ_RISE] = 1'b1;
    if (set_hit)
      next_st.irq_stat[`SEMC_IRQ_SET_HIT] = 1'b1;
    next_st.req_q = masked_any;

    // read data, one cycle after the strobe
    next_st.rdata = 32'h0000_0000;
    if (bus_req.rd)
    begin
      if (bus_req.addr == `SEMC_RAW_OFS)
        next_st.rdata = st.raw;
      else if (bus_req.addr == `SEMC_MASK_OFS)
        next_st.rdata = st.mask;
      else if (bus_req.addr == `SEMC_CLEAR_OFS)
        next_st.rdata = 32'h0000_0000;
      else if (bus_req.addr == `SEMC_SET_OFS)
        next_st.rdata = 32'h0000_0000;
      else if (bus_req.addr == `SEMC_IRQ_STAT_OFS)
        next_st.rdata = {30'h0, st.irq_stat};
      else if (bus_req.addr == `SEMC_IRQ_MASK_OFS)
        next_st.rdata = {30'h0, st.irq_mask};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st.raw      <= `SEMC_RAW_RST;
      st.mask     <= `SEMC_MASK_RST;
      st.rdata    <= 32'h0000_0000;
      st.irq_stat <= 2'h0;
      st.irq_mask <= 2'h0;
      st.req_q    <= 1'b0;
    end
    else
      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign bus_rdata        = st.rdata;
  assign event_raw_status = st.raw;
  assign service_req      = masked_any;
  assign irq              = |(st.irq_stat & st.irq_mask);

endmodule : semc_event_mask_clear

// *** tb/semc_properties.sv ***
`timescale 1ns/10ps
`include "semc_defs.svh"
////////////////////////////////////////////////////////////////////////////
// port-level checks of raw status, set, clear and read data
module semc_properties
  import semc_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 arst_n,
  input wire semc_pkg::semc_req_s  bus_req,
  input wire semc_pkg::semc_word_t bus_rdata,
  input wire semc_pkg::semc_word_t event_pulse,
  input wire semc_pkg::semc_word_t event_raw_status,
  input wire logic                 service_req,
  input wire logic                 irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // clear and set write decodes, raw read decode
  wire wc = bus_req.wr & (bus_req.addr == `SEMC_CLEAR_OFS);
  wire ws = bus_req.wr & (bus_req.addr == `SEMC_SET_OFS);
  wire rr = bus_req.rd & (bus_req.addr == `SEMC_RAW_OFS);
  property p_rq; service_req |-> |event_raw_status; endproperty
  a_rq: assert property (p_rq) else $error("request with no raw");
  property p_rb; (event_raw_status & ~`SEMC_RAW_BITS) == 0; endproperty
  a_rb: assert property (p_rb) else $error("reserved raw set");
  property p_ev; |event_pulse |=> &(event_raw_status | ~$past(event_pulse)
    | ~`SEMC_RAW_BITS); endproperty
  a_ev: assert property (p_ev) else $error("event not latched");
  property p_st; ws |=> &(event_raw_status | ~$past(bus_req.wdata)
    | ~`SEMC_RAW_BITS); endproperty
  a_st: assert property (p_st) else $error("set write lost");
  property p_cl; wc && event_pulse == 0 |=>
    (event_raw_status & $past(bus_req.wdata)) == 0; endproperty
  a_cl: assert property (p_cl) else $error("clear write lost");
  property p_fl; |($past(event_raw_status) & ~event_raw_status) |->
    $past(wc) && ($past(event_raw_status) & ~event_raw_status
    & ~$past(bus_req.wdata)) == 0; endproperty
  a_fl: assert property (p_fl) else $error("raw fell wrongly");
  property p_rr; rr |=> bus_rdata == $past(event_raw_status); endproperty
  a_rr: assert property (p_rr) else $error("raw read wrong");
  property p_rc; bus_req.rd && bus_req.addr == `SEMC_CLEAR_OFS |=>
    bus_rdata == 0; endproperty
  a_rc: assert property (p_rc) else $error("clear read not 0");
endmodule : semc_properties

bind semc_event_mask_clear semc_properties u_chk (.clk, .arst_n, .bus_req,
  .bus_rdata, .event_pulse, .event_raw_status, .service_req, .irq);

// *** tb/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  import semc_pkg::*;
  localparam semc_word_t RB = 32'hff7f_008f;
  localparam semc_word_t MB = 32'hff6f_0089;
  logic       clk = 0;
  logic       arst_n = 0;
  semc_req_s  bus_req = '0;
  semc_word_t event_pulse = '0;
  semc_word_t bus_rdata;
  semc_word_t event_raw_status;
  logic       service_req;
  logic       irq;
  int         n_fail = 0;
  int         n_checks = 0;
  ////////////////////////////////////////////////////////////////////////////
  // clock and device
  always #10 clk = ~clk;
  semc_event_mask_clear dut (.clk, .arst_n, .bus_req, .bus_rdata,
    .event_pulse, .event_raw_status, .service_req, .irq);
  ////////////////////////////////////////////////////////////////////////////
  // compare, bus cycles, verdict
  task chk(input string nm, input semc_word_t e, g);
    n_checks++;
    if (g !== e)
    begin
      $display("[FAIL] %s exp %h got %h", nm, e, g);
      n_fail++;
    end
  endtask : chk
  task wr(input semc_addr_t a, input semc_word_t d);
    @(posedge clk) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus_req <= '0;
    #1;
  endtask : wr
  task rd(input semc_addr_t a, input semc_word_t e);
    @(posedge clk) bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk) bus_req <= '0;
    #1 chk("rdata", e, bus_rdata);
  endtask : rd
  task complete_run;
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task t_reset;
    rd(8'h3c, 0);
    rd(8'h40, 0);
    rd(8'h10, 0);
  endtask : t_reset
  task t_set_irq;
    wr(8'h4c, 3);
    wr(8'h3c, '1);
    wr(8'h44, '1);
    chk("req", 1, service_req);
    rd(8'h38, RB);
    rd(8'h3c, MB);
    chk("irq", 1, irq);
    rd(8'h48, 3);
    chk("irq", 0, irq);
  endtask : t_set_irq
  task t_bits;
    for (int i = 0; i < 32; i++)
    begin
      wr(8'h3c, 32'h1 << i);
      chk("req", (MB >> i) & 1, service_req);
    end
  endtask : t_bits
  task t_clear;
    wr(8'h40, 32'h0010_0006);
    rd(8'h38, RB & ~32'h0010_0006);
    wr(8'h40, '1);
    rd(8'h38, 0);
  endtask : t_clear
  task t_event;
    wr(8'h4c, 0);
    wr(8'h3c, 0);
    @(posedge clk) event_pulse <= 32'h8000_0001;
    @(posedge clk) event_pulse <= 0;
    rd(8'h38, 32'h8000_0001);
    chk("req", 0, service_req);
    wr(8'h3c, 1);
    chk("req", 1, service_req);
    chk("irq", 0, irq);
    rd(8'h38, 32'h8000_0001);
    rd(8'h48, 1);
  endtask : t_event
  task t_rerst;
    wr(8'h3c, '1);
    @(posedge clk) arst_n <= 0;
    repeat (2) @(posedge clk);
    arst_n <= 1;
    #1 chk("req", 0, service_req);
    rd(8'h3c, 0);
    rd(8'h38, 0);
  endtask : t_rerst
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    arst_n <= 1;
    t_reset;
    t_set_irq;
    t_bits;
    t_clear;
    t_event;
    t_rerst;
    complete_run;
  end
  // watchdog
  initial
  begin
    #20000;
    n_fail++;
    complete_run;
  end
endmodule : testbench
